// ===== logic/irq_level_ctrl.sv
// interrupt level registers, in-service tracking and level arbitration
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module irq_level_ctrl (
    // clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_b_i,
    // register port
    input  wire irq_level_pkg::reg_req_t     reg_req_i,
    output logic [irq_level_pkg::DATA_W-1:0] rd_data_o,
    // pending requests from the core, already enable-qualified
    input  wire logic [irq_level_pkg::EXT_SRC-1:0] ext_req_i,
    input  wire logic [irq_level_pkg::SER_SRC-1:0] ser_req_i,
    // acceptance strobes from the core
    input  wire logic                        accept_i,
    input  wire logic                        nmi_accept_i,
    // arbitration result and status
    output irq_level_pkg::grant_t            grant_o,
    output logic                             nmi_in_service_o,
    output logic                             level_ctrl_on_o
);
    localparam int ALL_W = irq_level_pkg::EXT_SRC * irq_level_pkg::LEVEL_W
                         + irq_level_pkg::SER_USED_W;

    logic [15:0] enable_q;
    logic [15:0] ext_cfg_q;
    logic [15:0] ser_cfg_q;
    logic        nmi_q;
    logic [irq_level_pkg::MASK_W-1:0] msk_q;
    logic [15:0] rd_data_q;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // one-hot of the highest set bit
    function automatic logic [4:0] top_bit(input logic [4:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 5; i++) begin
            if (v[i]) begin
                r = 5'h01 << i;
            end
        end
        top_bit = r;
    endfunction

    wire logic level_ctrl_on = enable_q[irq_level_pkg::ENABLE_BIT];
    wire logic hit_en  = reg_req_i.addr == irq_level_pkg::ENABLE_OFS;
    wire logic hit_cur = reg_req_i.addr == irq_level_pkg::CUR_LEVEL_OFS;
    wire logic hit_ext = reg_req_i.addr == irq_level_pkg::EXT_CFG_OFS;
    wire logic hit_ser = reg_req_i.addr == irq_level_pkg::SER_CFG_OFS;
    // locked writes vanish silently; no error path exists on this port
    wire logic lvl_wr  = reg_req_i.wr & level_ctrl_on;
    wire logic en_wr   = reg_req_i.wr & hit_en;
    wire logic cur_wr  = lvl_wr & hit_cur;
    wire logic ext_wr  = lvl_wr & hit_ext;
    wire logic ser_wr  = lvl_wr & hit_ser;

    wire logic [ALL_W-1:0] all_cfg =
        {ser_cfg_q[irq_level_pkg::SER_USED_W-1:0], ext_cfg_q};
    wire logic [irq_level_pkg::SRC_N-1:0] req = {ser_req_i, ext_req_i};

    wire logic [4:0] ins = {nmi_q, msk_q};
    wire logic [4:0] ins_top = top_bit(ins);
    wire logic [4:0] clr = cur_wr ? ins_top : 5'h00;
    wire logic [4:0] set_lvl = (accept_i & grant_o.valid & level_ctrl_on)
        ? (5'h01 << grant_o.level) : 5'h00;
    wire logic [4:0] set_nmi = (nmi_accept_i & level_ctrl_on)
        ? 5'h10 : 5'h00;
    // set after clear so a same-cycle acceptance is never lost
    wire logic [4:0] ins_d = (ins & ~clr) | set_lvl | set_nmi;

    // lowest level still admitted; NMI in service blocks every maskable one
    logic [2:0] floor_lvl;
    always_comb begin
        floor_lvl = 3'h0;
        for (int i = 0; i < 5; i++) begin
            if (ins[i]) begin
                floor_lvl = 3'(i);
            end
        end
    end

    logic             best_v;
    logic [3:0]       best_s;
    logic [1:0]       best_l;
    always_comb begin
        logic [1:0] lv;
        logic       ok;
        lv = 2'h0;
        ok = 1'b0;
        best_v = 1'b0;
        best_s = 4'h0;
        best_l = 2'h0;
        for (int i = 0; i < irq_level_pkg::SRC_N; i++) begin
            lv = level_ctrl_on ? all_cfg[2*i +: 2] : 2'h0;
            ok = req[i] & (!level_ctrl_on
                 | ({1'b0, lv} >= floor_lvl));
            // strict compare keeps the lowest index on a tie
            if (ok && (!best_v || lv > best_l)) begin
                best_v = 1'b1;
                best_s = 4'(i);
                best_l = lv;
            end
        end
    end
    // one driver for the whole struct
    assign grant_o = '{valid: best_v, src: best_s, level: best_l};

    wire logic [15:0] cur_view = {8'h00, nmi_q, 3'h0, msk_q};
    wire logic [15:0] rd_mux =
        hit_en  ? enable_q  :
        hit_cur ? cur_view  :
        hit_ext ? ext_cfg_q :
        hit_ser ? ser_cfg_q : 16'h0000;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable_q  <= irq_level_pkg::REG_RST;
            ext_cfg_q <= irq_level_pkg::REG_RST;
            ser_cfg_q <= irq_level_pkg::REG_RST;
            nmi_q     <= 1'b0;
            msk_q     <= '0;
            rd_data_q <= 16'h0000;
        end else begin
            if (en_wr) begin
                enable_q <= merge(enable_q, reg_req_i.wdata, reg_req_i.be);
            end
            if (ext_wr) begin
                ext_cfg_q <= merge(ext_cfg_q, reg_req_i.wdata, reg_req_i.be);
            end
            if (ser_wr) begin
                ser_cfg_q <= merge(ser_cfg_q, reg_req_i.wdata, reg_req_i.be);
            end
            nmi_q     <= ins_d[4];
            msk_q     <= ins_d[3:0];
            rd_data_q <= reg_req_i.rd ? rd_mux : 16'h0000;
        end
    end

    assign rd_data_o        = rd_data_q;
    assign nmi_in_service_o = nmi_q;
    assign level_ctrl_on_o  = level_ctrl_on;

    chk_locked_write: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (reg_req_i.wr && hit_ext && !level_ctrl_on)
        |=> ext_cfg_q == $past(ext_cfg_q))
        else $error("level register changed while control disabled");

    chk_byte_half: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (ser_wr && reg_req_i.be == 2'b01)
        |=> ser_cfg_q[15:8] == $past(ser_cfg_q[15:8])
            && ser_cfg_q[7:0] == $past(reg_req_i.wdata[7:0]))
        else $error("low byte write disturbed the wrong half");

    chk_ext_readback: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (reg_req_i.rd && hit_ext)
        |=> rd_data_o == $past(ext_cfg_q))
        else $error("external level read data wrong");

    chk_ser_readback: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (reg_req_i.rd && hit_ser)
        |=> rd_data_o == $past(ser_cfg_q))
        else $error("serial level read data wrong");

    chk_nmi_set: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (nmi_accept_i && level_ctrl_on) |=> nmi_in_service_o)
        else $error("nmi acceptance did not set in-service bit");

    chk_clear_top: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (cur_wr && nmi_q && !nmi_accept_i)
        |=> !nmi_q && msk_q == ($past(msk_q)
            | $past(set_lvl[3:0])))
        else $error("write did not clear only the top bit");

    chk_floor: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (grant_o.valid && level_ctrl_on)
        |-> !nmi_q && {1'b0, grant_o.level} >= floor_lvl)
        else $error("grant below the in-service level");

    chk_level_map: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (grant_o.valid && level_ctrl_on)
        |-> grant_o.level == all_cfg[{grant_o.src, 1'b0} +: 2]
            && req[grant_o.src])
        else $error("grant level does not match its field");

    chk_unused_src: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        grant_o.valid |-> grant_o.src < 4'hF
            && req[grant_o.src])
        else $error("grant names a nonexistent source");

    chk_level_set: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (accept_i && grant_o.valid && level_ctrl_on)
        |=> msk_q[$past(grant_o.level)])
        else $error("acceptance did not mark its level");

    // any pending source whose field outranks the granted level
    logic outranked;
    always_comb begin
        outranked = 1'b0;
        for (int i = 0; i < irq_level_pkg::SRC_N; i++) begin
            if (req[i] && all_cfg[2*i +: 2] > grant_o.level) begin
                outranked = 1'b1;
            end
        end
    end

    chk_top_wins: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (grant_o.valid && level_ctrl_on) |-> !outranked)
        else $error("a higher level source lost arbitration");

    chk_ext_field: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (grant_o.valid && level_ctrl_on && !grant_o.src[3])
        |-> grant_o.level == ext_cfg_q[{grant_o.src[2:0], 1'b0} +: 2])
        else $error("external source level taken from the wrong field");

    chk_ser_field: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (grant_o.valid && level_ctrl_on && grant_o.src[3])
        |-> grant_o.level == ser_cfg_q[{grant_o.src[2:0], 1'b0} +: 2])
        else $error("serial source level taken from the wrong field");

    chk_locked_ser: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (reg_req_i.wr && hit_ser && !level_ctrl_on)
        |=> ser_cfg_q == $past(ser_cfg_q))
        else $error("serial level register changed while disabled");

    chk_locked_cur: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (reg_req_i.wr && hit_cur && !level_ctrl_on)
        |=> {nmi_q, msk_q} == $past({nmi_q, msk_q}))
        else $error("in-service bits changed while control disabled");

    chk_ext_word: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (ext_wr && reg_req_i.be == 2'b11)
        |=> ext_cfg_q == $past(reg_req_i.wdata))
        else $error("word write to external levels not stored");

    chk_ext_high: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (ext_wr && reg_req_i.be == 2'b10)
        |=> ext_cfg_q[7:0] == $past(ext_cfg_q[7:0])
            && ext_cfg_q[15:8] == $past(reg_req_i.wdata[15:8]))
        else $error("high byte write disturbed the wrong half");

    chk_ser_word: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (ser_wr && reg_req_i.be == 2'b11)
        |=> ser_cfg_q == $past(reg_req_i.wdata))
        else $error("word write to serial levels not stored");

    chk_nmi_view: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (reg_req_i.rd && hit_cur)
        |=> rd_data_o[7] == $past(nmi_q) && rd_data_o[3:0] == $past(msk_q)
            && rd_data_o[15:8] == 8'h00 && rd_data_o[6:4] == 3'h0)
        else $error("current level read data wrong");

    chk_enable_write: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (en_wr && reg_req_i.be[0])
        |=> level_ctrl_on_o == $past(reg_req_i.wdata[0]))
        else $error("enable bit did not follow its write");

    chk_frozen_off: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        !level_ctrl_on
        |=> {nmi_q, msk_q} == $past({nmi_q, msk_q}))
        else $error("in-service bits moved while control disabled");

    chk_clear_mask: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (cur_wr && !nmi_q && msk_q != 4'h0 && !accept_i && !nmi_accept_i)
        |=> $onehot($past(msk_q) ^ msk_q)
            && ($past(msk_q) ^ msk_q) > msk_q
            && (msk_q & ~$past(msk_q)) == 4'h0)
        else $error("write cleared a level bit other than the top one");

    chk_off_level: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (grant_o.valid && !level_ctrl_on)
        |-> grant_o.level == 2'h0 && req[grant_o.src])
        else $error("levels applied while control disabled");

    chk_nmi_refuse: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (nmi_q && level_ctrl_on) |-> !grant_o.valid)
        else $error("maskable grant during nmi service");
endmodule
`default_nettype wire

// ===== logic/irq_level_pkg.sv
// constants and carrier types for the interrupt level control block
// Behaviour
// - bit 7 of the current level register reads 1 while an NMI is serviced.
// - external level register sits at F024h, 16-bit read/write, resets to zero.
// - level registers accept byte writes to either half and whole-word writes.
// - level registers update only while level control is enabled.
// - each source has a 2-bit field, 00 is level 1 up to 11 level 4.
// - a pending source with higher level wins over one with lower level.
// - first register serves enable-register-one sources, second serves register two.
// - external interrupts 0 to 3 use low byte fields, two bits each.
// - external interrupts 4 to 7 use high byte fields, two bits each.
// - serial level register sits at F026h, 16-bit read/write, resets to zero.
// - sync serial at bits 1:0, sync serial with FIFO at bits 3:2.
// - I2C bus zero at bits 5:4, I2C bus one at bits 7:6.
// - UART receive 9:8, UART transmit 11:10, UART FIFO 13:12.
// - enable bit 0 switches level control on, resets to off.
// - accepting sets NMI in-service bit, or the bit of the source level, while level control is enabled.
// - a write to the current level register clears its top set bit only while level control is enabled.
// - maskable requests below the top in-service level are refused while level control is enabled.
package irq_level_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] ENABLE_OFS    = 16'hF020;
    localparam logic [15:0] CUR_LEVEL_OFS = 16'hF022;
    localparam logic [15:0] EXT_CFG_OFS   = 16'hF024;
    localparam logic [15:0] SER_CFG_OFS   = 16'hF026;
    localparam logic [15:0] REG_RST       = 16'h0000;
    localparam int ENABLE_BIT = 0;
    localparam int NMI_BIT    = 7;
    localparam int MASK_W     = 4;
    localparam int LEVEL_W    = 2;
    localparam int EXT_SRC    = 8;
    localparam int SER_SRC    = 7;
    localparam int SRC_N      = 15;
    localparam int SER_USED_W = 14;
    localparam int SRC_W      = 4;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0]  be;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic             valid;
        logic [SRC_W-1:0] src;
        logic [1:0]       level;
    } grant_t;
endpackage

// ===== verification/core_accept_model.sv
// core-side model: accepts the offered grant or an nmi when told to
`timescale 1ns/1ps
`default_nettype none
module core_accept_model (
    // commands from the bench
    input  wire logic                  take_i,
    input  wire logic                  take_nmi_i,
    // arbitration result from the block
    input  wire irq_level_pkg::grant_t grant_i,
    // acceptance strobes
    output logic                       accept_o,
    output logic                       nmi_accept_o
);
    // never accepts a grant that is not on offer
    assign accept_o     = take_i & grant_i.valid;
    assign nmi_accept_o = take_nmi_i;
endmodule
`default_nettype wire

// ===== verification/interrupt_level_control_regs_test.sv
// self-checking bench for the level registers and level arbitration
`timescale 1ns/1ps
`default_nettype none
module interrupt_level_control_regs_test;
    logic                    clk = 1'b0;
    logic                    rst_b = 1'b0;
    irq_level_pkg::reg_req_t req = '0;
    logic [15:0]             rd_data;
    logic [14:0]             pend = '0;
    logic                    take = 1'b0;
    logic                    take_nmi = 1'b0;
    logic                    accept;
    logic                    nmi_accept;
    irq_level_pkg::grant_t   grant;
    logic                    nmi_busy;
    logic                    level_on;
    logic [29:0]             cfg;
    int                      bad_count = 0;
    int                      num_checks = 0;

    always #4 clk = ~clk;

    irq_level_ctrl DUT (.clk_sys_i(clk), .rst_b_i(rst_b), .reg_req_i(req),
        .rd_data_o(rd_data), .ext_req_i(pend[7:0]), .ser_req_i(pend[14:8]),
        .accept_i(accept), .nmi_accept_i(nmi_accept), .grant_o(grant),
        .nmi_in_service_o(nmi_busy), .level_ctrl_on_o(level_on));
    core_accept_model core (.take_i(take), .take_nmi_i(take_nmi),
        .grant_i(grant), .accept_o(accept), .nmi_accept_o(nmi_accept));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, d, input logic [1:0] be);
        @(posedge clk);
        req <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, be: 2'b00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk(rd_data, exp);
    endtask
    // src and level are only meaningful while valid
    task automatic offer(input logic [14:0] r, input logic [6:0] exp);
        @(posedge clk);
        pend <= r;
        @(negedge clk);
        chk(exp[6] ? {9'h000, grant} : {15'h0000, grant.valid}, {9'h000, exp});
    endtask
    task automatic pulse(input logic nmi);
        @(posedge clk);
        take <= !nmi;
        take_nmi <= nmi;
        @(posedge clk);
        take <= 1'b0;
        take_nmi <= 1'b0;
    endtask
    // drops every request before the level registers are rewritten
    task automatic quiet;
        @(posedge clk);
        pend <= '0;
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #20000;
        bad_count++;
        $display("ERROR %0t: timeout", $time);
        conclude();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk({14'h0000, nmi_busy, level_on}, 16'h0000);
        rd(16'hF024, 16'h0000);
        rd(16'hF026, 16'h0000);
        rd(16'hF022, 16'h0000);
        wr(16'hF024, 16'hFFFF, 2'b11);
        rd(16'hF024, 16'h0000);
        wr(16'hF020, 16'h0001, 2'b01);
        rd(16'hF020, 16'h0001);
        chk({15'h0000, level_on}, 16'h0001);
        wr(16'hF024, 16'h00E4, 2'b01);
        wr(16'hF024, 16'h1BFF, 2'b10);
        rd(16'hF024, 16'h1BE4);
        wr(16'hF026, 16'h3FA5, 2'b01);
        rd(16'hF026, 16'h00A5);
        wr(16'hF02E, 16'hFFFF, 2'b11);
        rd(16'hF02E, 16'h0000);
        // one source raised per pass, all pending; top bits of F026 set
        for (int i = 0; i < 15; i++) begin
            quiet();
            cfg = 30'((i % 3) + 1) << (2 * i);
            wr(16'hF024, cfg[15:0], 2'b11);
            wr(16'hF026, {2'b11, cfg[29:16]}, 2'b11);
            offer(15'h7FFF, {1'b1, 4'(i), 2'((i % 3) + 1)});
        end
        quiet();
        wr(16'hF026, 16'h0000, 2'b11);
        wr(16'hF024, 16'h0006, 2'b11);
        offer(15'h0004, {1'b1, 4'd2, 2'd0});
        offer(15'h0003, {1'b1, 4'd0, 2'd2});
        pulse(1'b0);
        rd(16'hF022, 16'h0004);
        offer(15'h0002, 7'h00);
        offer(15'h0001, {1'b1, 4'd0, 2'd2});
        pulse(1'b1);
        rd(16'hF022, 16'h0084);
        offer(15'h0001, 7'h00);
        wr(16'hF022, 16'h0000, 2'b11);
        rd(16'hF022, 16'h0004);
        chk({15'h0000, nmi_busy}, 16'h0000);
        // switched off: fields ignored, held in-service bits stay put
        wr(16'hF020, 16'h0000, 2'b01);
        offer(15'h0001, {1'b1, 4'd0, 2'd0});
        wr(16'hF022, 16'h0000, 2'b11);
        rd(16'hF022, 16'h0004);
        wr(16'hF020, 16'h0001, 2'b01);
        wr(16'hF022, 16'h0000, 2'b11);
        rd(16'hF022, 16'h0000);
        offer(15'h0002, {1'b1, 4'd1, 2'd1});
        quiet();
        wr(16'hF020, 16'h0000, 2'b11);
        wr(16'hF024, 16'hFFFF, 2'b11);
        wr(16'hF026, 16'hFFFF, 2'b11);
        rd(16'hF024, 16'h0006);
        rd(16'hF026, 16'h0000);
        // mid-run reset must bring the stored fields back to zero
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        rd(16'hF024, 16'h0000);
        rd(16'hF020, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
